// file: rtl/tmr_regs.vh
`ifndef TMR_REGS_VH
`define TMR_REGS_VH

// ************************************************************
// Timing constants
// ************************************************************
// Base tick every 16 input clocks: prescaler terminal count
`define TMR_PRESCALE_LAST 4'hF
// Terminal value of the free-running up-counters
`define TMR_UP_MAX        16'hFFFF
// Least spacing of service writes, in base timer counts
`define TMR_WD_MIN_COUNTS 13'h1000
// Base timer overflows without a service write that raise the fault
`define TMR_WD_OVF_LIMIT  2'h2

// ************************************************************
// Clock source codes of the clock divider control
// ************************************************************
`define TMR_SRC_DIV       2'h0
`define TMR_SRC_PIN       2'h1
`define TMR_SRC_CASCADE   2'h2

// ************************************************************
// Software access select: bit 3 picks reload, bits 2:0 index
// ************************************************************
`define TMR_SEL_RELOAD_BIT 3
`define TMR_SEL_IDX_MSB    2
`define TMR_PAIR_COUNT     7

// ************************************************************
// Event pin configuration fields
// ************************************************************
`define TMR_EVT_POL_BIT   0
`define TMR_EVT_LEVEL_BIT 1

// ************************************************************
// Reset values
// ************************************************************
`define TMR_ZERO16        16'h0000
`define TMR_PORT_RESET    4'h0

`endif

// file: rtl/tmr_sync.v
`timescale 1ns/1ps
`include "tmr_regs.vh"

// ************************************************************
// Two-stage synchroniser for a group of pin levels
// ************************************************************
module tmr_sync #(
  parameter W = 4
) (
  // Clock and reset
  input  wire         clk,
  input  wire         rst,
  // Pin side and clock side
  input  wire [W-1:0] pin_in,
  output reg  [W-1:0] pin_sync_q
);

  reg [W-1:0] meta_q;

  // First stage feeds only the second stage
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q     <= {W{1'b0}};
      pin_sync_q <= {W{1'b0}};
    end else begin
      meta_q     <= pin_in;
      pin_sync_q <= meta_q;
    end
  end

endmodule // tmr_sync

// file: rtl/tmr_pair.v
`timescale 1ns/1ps
`include "tmr_regs.vh"

// ************************************************************
// Down-counting timer with its reload register
// ************************************************************
module tmr_pair (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Counting control
  input  wire        tick,
  input  wire        run,
  // Loads from software or capture logic
  input  wire        ld_timer,
  input  wire        ld_reload,
  input  wire [15:0] ld_val,
  // State
  output reg  [15:0] timer_q,
  output reg  [15:0] reload_q,
  output wire        underflow
);

  // Underflow is the count clock arriving at zero
  assign underflow = tick & run & (timer_q == `TMR_ZERO16);

  // Loads win over counting so a write is never half taken
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      timer_q  <= `TMR_ZERO16;
      reload_q <= `TMR_ZERO16;
    end else begin
      if (ld_reload)
        reload_q <= ld_val;
      if (ld_timer)
        timer_q <= ld_val;
      else if (underflow)
        timer_q <= reload_q;
      else if (tick && run)
        timer_q <= timer_q - 16'h0001;
    end
  end

endmodule // tmr_pair

// file: rtl/tmr_top.v
`timescale 1ns/1ps
`include "tmr_regs.vh"

// Function
// - Base timer counts up every 16 clocks
// - Base timer cannot be stopped or written
// - Three captures latch base timer on pins
// - Edge select per capture, optional interrupt
// - Mode bit turns pair one into captures
// - Second free timer captured on event pin
// - Event config selects mode and polarity
// - Timers two, three: pin or divided clock
// - Timer two may count timer three underflows
// - Timers one to seven reload on underflow
// - Software reads, writes, starts, stops pairs
// - Sync outputs plain or toggle on underflow
// - Four pulse pairs drive pulse port bits
// - Zero timer and reload toggle on every count tick
// - Mode control: run and interrupt bits
// - Pulse control: start, stop, interrupt bits
// - Port control: preset levels, sync enables
// - Fault on missing or too-frequent service
// - Fault on illegal address in single-chip
// - Any fault pulls open-drain fault low
// - Reset drives pulse port low
// - Base timer overflow wakes from idle
// - External access bit disables address check
// - Edge condition bits set pin polarity
module tmr_top (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // External pins
  input  wire        irq_pin_a,
  input  wire        irq_pin_b,
  input  wire        irq_pin_c,
  input  wire        event_irq_pin,
  input  wire        t2_clk_pin,
  input  wire        t3_clk_pin,
  // Timer mode control
  input  wire [2:0]  timer_run,
  input  wire        capture_mode,
  input  wire [3:0]  timer_int_en,
  input  wire [3:0]  timer_int_ack,
  // Capture and event configuration
  input  wire [2:0]  edge_condition_reg,
  input  wire [2:0]  capture_int_en,
  input  wire [2:0]  capture_int_ack,
  input  wire [1:0]  event_pin_config,
  input  wire        event_int_en,
  input  wire        event_int_ack,
  // Clock divider control
  input  wire [1:0]  t2_src_sel,
  input  wire        t3_src_sel,
  input  wire [3:0]  t2_div_sel,
  input  wire [3:0]  t3_div_sel,
  // Pulse timer control
  input  wire [3:0]  pulse_start,
  input  wire [3:0]  pulse_stop,
  input  wire [3:0]  pulse_int_en,
  input  wire [3:0]  pulse_int_ack,
  // Pulse port control
  input  wire        pulse_preset_wr,
  input  wire [3:0]  pulse_preset_val,
  input  wire [3:0]  pulse_sync_en,
  // Synchronous output control
  input  wire [3:0]  sync_toggle_mode,
  input  wire [3:0]  sync_plain_val,
  // Software access to timer and reload registers
  input  wire        sw_wr,
  input  wire [3:0]  sw_wr_sel,
  input  wire [15:0] sw_wr_data,
  input  wire [3:0]  sw_rd_sel,
  // Supervisor inputs
  input  wire        service_wr,
  input  wire        illegal_addr,
  input  wire        single_chip,
  input  wire        external_access_bit,
  // Timer state
  output reg  [15:0] base_timer_q,
  output reg  [15:0] event_base_timer_q,
  output reg  [15:0] capture_reg_a_q,
  output reg  [15:0] capture_reg_b_q,
  output reg  [15:0] capture_reg_c_q,
  output reg  [15:0] event_capture_reg_q,
  output reg  [15:0] sw_rd_data_q,
  // Interrupt latches and requests
  output reg  [3:0]  timer_int_q,
  output reg  [3:0]  pulse_int_q,
  output reg  [2:0]  capture_pend_q,
  output reg         event_pend_q,
  output reg         irq_q,
  // Output ports
  output reg  [3:0]  sync_out_q,
  output reg  [3:0]  pulse_out_q,
  // Idle wake and open-drain fault pin
  output reg         wake_q,
  output reg         fault_out_n_o_q,
  output reg         fault_out_n_oe_n_q
);

  // ************************************************************
  // Pin synchronisers and edge detection
  // ************************************************************
  wire [5:0] pin_s;
  reg  [5:0] pin_prev_q;
  wire [5:0] pin_rise;
  wire [5:0] pin_fall;

  // Every pin passes two flops first
  tmr_sync #(
    .W (6)
  ) u_sync (
    .clk        (clk),
    .rst        (rst),
    .pin_in     ({t3_clk_pin, t2_clk_pin, event_irq_pin,
                  irq_pin_c, irq_pin_b, irq_pin_a}),
    .pin_sync_q (pin_s)
  );

  // Edge history taken after the synchroniser
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_prev_q <= 6'h00;
    end else begin
      pin_prev_q <= pin_s;
    end
  end

  // One pulse per edge, never repeated
  assign pin_rise = pin_s & ~pin_prev_q;
  assign pin_fall = ~pin_s & pin_prev_q;

  // ************************************************************
  // Capture event selection
  // ************************************************************
  wire [2:0] cap_evt;
  wire       evt_edge;
  wire       evt_level;
  wire       evt_hit;

  // Polarity bit per pin: one picks rising
  assign cap_evt = (edge_condition_reg & pin_rise[2:0]) |
                   (~edge_condition_reg & pin_fall[2:0]);

  // Event pin: edge or level, high or low
  assign evt_edge  = event_pin_config[`TMR_EVT_POL_BIT] ?
                     pin_rise[3] : pin_fall[3];
  assign evt_level = ~(pin_s[3] ^ event_pin_config[`TMR_EVT_POL_BIT]);
  assign evt_hit   = event_pin_config[`TMR_EVT_LEVEL_BIT] ?
                     evt_level : evt_edge;

  // ************************************************************
  // Base prescaler and free-running up-counters
  // ************************************************************
  reg  [3:0]  pre_q;
  wire        base_tick;
  wire        base_ovf;

  // Shared divide-by-16 tick
  assign base_tick = (pre_q == `TMR_PRESCALE_LAST);
  assign base_ovf  = base_tick & (base_timer_q == `TMR_UP_MAX);

  // No write or stop path exists by design
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_q              <= 4'h0;
      base_timer_q       <= `TMR_ZERO16;
      event_base_timer_q <= `TMR_ZERO16;
      wake_q             <= 1'b0;
    end else begin
      pre_q <= pre_q + 4'h1;
      if (base_tick) begin
        base_timer_q       <= base_timer_q + 16'h0001;
        event_base_timer_q <= event_base_timer_q + 16'h0001;
      end
      wake_q <= base_ovf; // Idle exit pulse
    end
  end

  // ************************************************************
  // Internal divider for timers two and three
  // ************************************************************
  reg  [15:0] div_q;
  wire [15:0] t2_mask;
  wire [15:0] t3_mask;
  wire        t2_div_tick;
  wire        t3_div_tick;

  // Tick when the low selected bits are all ones
  assign t2_mask = (16'h0002 << t2_div_sel) - 16'h0001;
  assign t3_mask = (16'h0002 << t3_div_sel) - 16'h0001;
  assign t2_div_tick = ((div_q & t2_mask) == t2_mask);
  assign t3_div_tick = ((div_q & t3_mask) == t3_mask);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      div_q <= `TMR_ZERO16;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  // ************************************************************
  // Seven timer and reload pairs
  // ************************************************************
  wire [6:0]   pair_tick;
  wire [6:0]   pair_run;
  wire [6:0]   pair_uf;
  wire [111:0] pair_timer;
  wire [111:0] pair_reload;
  reg  [3:0]   pulse_run_q;
  reg          t2_tick;
  wire         t3_tick;

  // Timer three: pin edge or divided clock
  assign t3_tick = t3_src_sel ? pin_rise[5] : t3_div_tick;

  // Timer two adds cascade from timer three
  always @* begin
    case (t2_src_sel)
      `TMR_SRC_DIV:     t2_tick = t2_div_tick;
      `TMR_SRC_PIN:     t2_tick = pin_rise[4];
      `TMR_SRC_CASCADE: t2_tick = pair_uf[2];
      default:          t2_tick = t2_div_tick;
    endcase
  end

  // Pair one stops counting while it serves as captures
  assign pair_tick = {{4{base_tick}}, t3_tick, t2_tick, base_tick};
  assign pair_run  = {pulse_run_q, timer_run[2:1],
                      timer_run[0] & ~capture_mode};

  genvar gi;
  generate
    for (gi = 0; gi < `TMR_PAIR_COUNT; gi = gi + 1) begin : g_pair
      wire        sw_hit;
      wire        cap_t;
      wire        cap_r;

      // Software write decode
      assign sw_hit = sw_wr &&
                      (sw_wr_sel[`TMR_SEL_IDX_MSB:0] == gi);
      // Pair one in capture mode: reload takes pin a, timer pin b
      assign cap_t = (gi == 0) && capture_mode && cap_evt[1];
      assign cap_r = (gi == 0) && capture_mode && cap_evt[0];

      // Count down and reload on underflow
      tmr_pair u_pair (
        .clk       (clk),
        .rst       (rst),
        .tick      (pair_tick[gi]),
        .run       (pair_run[gi]),
        .ld_timer  (cap_t |
                    (sw_hit & ~sw_wr_sel[`TMR_SEL_RELOAD_BIT])),
        .ld_reload (cap_r |
                    (sw_hit & sw_wr_sel[`TMR_SEL_RELOAD_BIT])),
        .ld_val    ((cap_t | cap_r) ? base_timer_q : sw_wr_data),
        .timer_q   (pair_timer[gi*16 +: 16]),
        .reload_q  (pair_reload[gi*16 +: 16]),
        .underflow (pair_uf[gi])
      );
    end
  endgenerate

  // ************************************************************
  // Capture registers
  // ************************************************************
  // Registers a and b mirror pair one while in capture mode
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      capture_reg_a_q     <= `TMR_ZERO16;
      capture_reg_b_q     <= `TMR_ZERO16;
      capture_reg_c_q     <= `TMR_ZERO16;
      event_capture_reg_q <= `TMR_ZERO16;
    end else begin
      if (cap_evt[0])
        capture_reg_a_q <= base_timer_q;
      if (cap_evt[1])
        capture_reg_b_q <= base_timer_q;
      if (cap_evt[2])
        capture_reg_c_q <= base_timer_q;
      if (evt_hit)
        event_capture_reg_q <= event_base_timer_q;
    end
  end

  // ************************************************************
  // Software read path
  // ************************************************************
  wire [2:0] rd_idx;
  assign rd_idx = sw_rd_sel[`TMR_SEL_IDX_MSB:0];

  // Registered read, one cycle behind the select
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sw_rd_data_q <= `TMR_ZERO16;
    end else if (rd_idx == 3'h7) begin
      sw_rd_data_q <= `TMR_ZERO16;
    end else if (sw_rd_sel[`TMR_SEL_RELOAD_BIT]) begin
      sw_rd_data_q <= pair_reload[rd_idx*16 +: 16];
    end else begin
      sw_rd_data_q <= pair_timer[rd_idx*16 +: 16];
    end
  end

  // ************************************************************
  // Pulse timer run state
  // ************************************************************
  // Stop wins when both arrive together
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pulse_run_q <= 4'h0;
    end else begin
      pulse_run_q <= (pulse_run_q | pulse_start) & ~pulse_stop;
    end
  end

  // ************************************************************
  // Interrupt latches
  // ************************************************************
  wire [3:0] timer_evt;
  assign timer_evt = {pair_uf[2:0], base_ovf};

  // Hardware set beats software acknowledge in the same cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      timer_int_q    <= 4'h0;
      pulse_int_q    <= 4'h0;
      capture_pend_q <= 3'h0;
      event_pend_q   <= 1'b0;
      irq_q          <= 1'b0;
    end else begin
      timer_int_q    <= timer_evt |
                        (timer_int_q & ~timer_int_ack);
      pulse_int_q    <= pair_uf[6:3] |
                        (pulse_int_q & ~pulse_int_ack);
      capture_pend_q <= cap_evt |
                        (capture_pend_q & ~capture_int_ack);
      event_pend_q   <= evt_hit | (event_pend_q & ~event_int_ack);
      irq_q          <= |(timer_int_q & timer_int_en) |
                        |(pulse_int_q & pulse_int_en) |
                        |(capture_pend_q & capture_int_en) |
                        (event_pend_q & event_int_en);
    end
  end

  // ************************************************************
  // Synchronous outputs and pulse port
  // ************************************************************
  // Sync outputs follow timer two underflows when selected
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_out_q <= `TMR_PORT_RESET;
    end else begin
      sync_out_q <= (sync_toggle_mode &
                     (sync_out_q ^ {4{pair_uf[1]}})) |
                    (~sync_toggle_mode & sync_plain_val);
    end
  end

  // Preset overrides toggling; reset leaves the port low
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pulse_out_q <= `TMR_PORT_RESET;
    end else if (pulse_preset_wr) begin
      pulse_out_q <= pulse_preset_val;
    end else begin
      pulse_out_q <= pulse_out_q ^
                     (pulse_sync_en & pair_uf[6:3]);
    end
  end

  // ************************************************************
  // Supervisor
  // ************************************************************
  reg  [1:0]  wd_ovf_q;
  reg  [12:0] wd_since_q;
  reg         wd_armed_q;
  reg         fault_q;
  wire        wd_too_soon;
  wire        wd_starved;
  wire        wd_bad_addr;

  // First service after reset only arms the spacing check
  assign wd_too_soon = service_wr & wd_armed_q &
                       (wd_since_q < `TMR_WD_MIN_COUNTS);
  assign wd_starved  = (wd_ovf_q == `TMR_WD_OVF_LIMIT);
  // Expanded access masks the address
  assign wd_bad_addr = illegal_addr & single_chip & ~external_access_bit;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wd_ovf_q   <= 2'h0;
      wd_since_q <= 13'h0000;
      wd_armed_q <= 1'b0;
      fault_q    <= 1'b0;
    end else begin
      if (service_wr) begin
        wd_ovf_q   <= 2'h0;
        wd_since_q <= 13'h0000;
        wd_armed_q <= 1'b1;
      end else begin
        if (base_ovf && !wd_starved)
          wd_ovf_q <= wd_ovf_q + 2'h1;
        // Saturate so a long gap never wraps into too soon
        if (base_tick && (wd_since_q < `TMR_WD_MIN_COUNTS))
          wd_since_q <= wd_since_q + 13'h0001;
      end
      // Sticky until reset
      if (wd_too_soon || wd_starved || wd_bad_addr)
        fault_q <= 1'b1;
    end
  end

  // Open drain: data low, enable low while pulling
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      fault_out_n_o_q    <= 1'b0;
      fault_out_n_oe_n_q <= 1'b1;
    end else begin
      fault_out_n_o_q    <= 1'b0;
      fault_out_n_oe_n_q <= ~fault_q;
    end
  end

endmodule // tmr_top

// file: tb/tmr_top_checker.sv
`timescale 1ns/1ps

// ********
// Port checks of the timer block
// ********
module tmr_top_checker (
  // Clock and reset
  input logic        clk,
  input logic        rst,
  // Counters
  input logic [15:0] base_timer_q,
  input logic [15:0] event_base_timer_q,
  // Latches and request
  input logic [2:0]  capture_pend_q,
  input logic [2:0]  capture_int_en,
  input logic        event_pend_q,
  input logic        event_int_en,
  input logic        irq_q,
  // Supervisor
  input logic        illegal_addr,
  input logic        single_chip,
  input logic        external_access_bit,
  input logic        fault_out_n_o_q,
  input logic        fault_out_n_oe_n_q,
  input logic        wake_q,
  // Ports
  input logic [3:0]  sync_toggle_mode,
  input logic [3:0]  sync_plain_val,
  input logic [3:0]  sync_out_q,
  input logic [3:0]  pulse_out_q
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Counter step and spacing
  base_step_a: assert property (
    $changed(base_timer_q) |-> base_timer_q == $past(base_timer_q) + 16'h1)
    else $error("base timer step wrong");
  base_rate_a: assert property (
    $changed(base_timer_q) |=> $stable(base_timer_q)[*8] ##8
      $changed(base_timer_q))
    else $error("base timer rate wrong");
  event_base_a: assert property (
    event_base_timer_q == base_timer_q)
    else $error("event base timer differs");

  // Requests follow enabled latches one cycle later
  cap_irq_a: assert property (
    (capture_pend_q & capture_int_en) != 3'h0 |=> irq_q)
    else $error("capture request missing");
  evt_irq_a: assert property (
    event_pend_q && event_int_en |=> irq_q)
    else $error("event request missing");

  // Supervisor pin
  illegal_addr_a: assert property (
    illegal_addr && single_chip && !external_access_bit |->
      ##2 !fault_out_n_oe_n_q)
    else $error("illegal address not flagged");
  fault_hold_a: assert property (
    !fault_out_n_oe_n_q |=> !fault_out_n_oe_n_q)
    else $error("fault released early");
  fault_pull_a: assert property (
    !fault_out_n_oe_n_q |-> fault_out_n_o_q == 1'b0)
    else $error("fault pin not pulled low");
  wake_wrap_a: assert property (
    wake_q |-> base_timer_q == 16'h0000 && $past(base_timer_q) == 16'hFFFF)
    else $error("wake without base overflow");

  // Ports
  sync_plain_a: assert property (
    sync_toggle_mode == 4'h0 ##1 sync_toggle_mode == 4'h0 |->
      sync_out_q == $past(sync_plain_val))
    else $error("plain sync output wrong");
  pulse_rst_a: assert property (
    $fell(rst) |-> pulse_out_q == 4'h0)
    else $error("pulse port not low after reset");

  // Main scenarios reached
  cover property (capture_pend_q != 3'h0);
  cover property (!fault_out_n_oe_n_q);
  cover property ($changed(sync_out_q));
endmodule // tmr_top_checker

bind tmr_top tmr_top_checker chk_i (.*);

// file: tb/tb_tmr_top.sv
`timescale 1ns/1ps

// ********
// Bench of the timer block
// ********
module tb_tmr_top;
  // Inputs, all quiet at time zero except rst, which starts high
  logic        clk;
  logic        rst = 1;
  logic [3:0]  pins = 4'h0;
  logic        t2_clk_pin = 0, capture_mode = 0, event_int_en = 0;
  logic        event_int_ack = 0, t3_src_sel = 0, pulse_preset_wr = 0;
  logic        sw_wr = 0, service_wr = 0, illegal_addr = 0;
  logic        single_chip = 0, external_access_bit = 0;
  logic [1:0]  event_pin_config = 2'h0, t2_src_sel = 2'h0;
  logic [2:0]  timer_run = 3'h0, edge_condition_reg = 3'h0;
  logic [2:0]  capture_int_en = 3'h0, capture_int_ack = 3'h0;
  logic [3:0]  timer_int_en = 4'h0, timer_int_ack = 4'h0;
  logic [3:0]  t2_div_sel = 4'h0, t3_div_sel = 4'h0;
  logic [3:0]  pulse_start = 4'h0, pulse_stop = 4'h0;
  logic [3:0]  pulse_int_en = 4'h0, pulse_int_ack = 4'h0;
  logic [3:0]  pulse_preset_val = 4'h0, pulse_sync_en = 4'h0;
  logic [3:0]  sync_toggle_mode = 4'h0, sync_plain_val = 4'h0;
  logic [3:0]  sw_wr_sel = 4'h0, sw_rd_sel = 4'h0;
  logic [15:0] sw_wr_data = 16'h0000;
  // Outputs
  logic        wake_q, fault_out_n_o_q, fault_out_n_oe_n_q;
  logic        event_pend_q, irq_q;
  logic [2:0]  capture_pend_q;
  logic [3:0]  timer_int_q, pulse_int_q, sync_out_q, pulse_out_q;
  logic [15:0] base_timer_q, event_base_timer_q, capture_reg_a_q;
  logic [15:0] capture_reg_b_q, capture_reg_c_q, event_capture_reg_q;
  logic [15:0] sw_rd_data_q, rdv, lo;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  // Pin and output groupings for loops
  wire         irq_pin_a = pins[0];
  wire         irq_pin_b = pins[1];
  wire         irq_pin_c = pins[2];
  wire         event_irq_pin = pins[3];
  wire         t3_clk_pin = t2_clk_pin;
  wire [7:0]   outs = {sync_out_q, pulse_out_q};
  wire [3:0]   pend = {event_pend_q, capture_pend_q};
  wire [63:0]  caps = {event_capture_reg_q, capture_reg_c_q,
                       capture_reg_b_q, capture_reg_a_q};

  tmr_top dut (.*);

  // Clock, and a pin clock rising every 8 cycles on falling edges
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always #40 t2_clk_pin = ~t2_clk_pin;

  // ********
  // Tasks
  // ********
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic w(int n);
    repeat (n) @(negedge clk);
  endtask

  // Strobe is dropped for a cycle so back-to-back calls never clash
  task automatic wr(logic [3:0] s, logic [15:0] d);
    sw_wr = 1;
    sw_wr_sel = s;
    sw_wr_data = d;
    w(1);
    sw_wr = 0;
    w(1);
  endtask

  task automatic rd(logic [3:0] s);
    sw_rd_sel = s;
    repeat (2) @(posedge clk);
    #1 rdv = sw_rd_data_q;
    w(1);
  endtask

  // Cycles between two changes of one output bit
  task automatic per(int b, int e);
    int n;
    logic v;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      v = outs[b];
      while (outs[b] === v && n < 300) begin
        @(posedge clk);
        #1 n++;
      end
    end
    chk("period", 16'(n), 16'(e));
    w(1);
  endtask

  task automatic do_rst;
    rst = 1;
    w(6);
    chk("rst_port", pulse_out_q, 4'h0);
    chk("rst_fault", fault_out_n_oe_n_q, 1'b1);
    rst = 0;
    w(1);
  endtask

  task automatic end_sim;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // A hang counts as a mismatch
  initial begin
    #400000;
    n_mismatch++;
    end_sim;
  end

  // ********
  // Tests
  // ********
  initial begin
    do_rst;
    for (int i = 0; i < 7; i++) begin
      wr(4'(i), {4'(i), 12'hA5C});
      wr(4'h8 | 4'(i), {4'(i), 12'h3C1});
    end
    for (int i = 0; i < 8; i++) begin
      rd(4'(i));
      chk("timer", rdv, i < 7 ? {4'(i), 12'hA5C} : 16'h0000);
      rd(4'h8 | 4'(i));
      chk("reload", rdv, i < 7 ? {4'(i), 12'h3C1} : 16'h0000);
    end
    pulse_preset_val = 4'hA;
    pulse_preset_wr = 1;
    w(1);
    pulse_preset_wr = 0;
    w(1);
    chk("preset", pulse_out_q, 4'hA);
    // Pulse unit: reload 2 gives an underflow every 3 ticks
    wr(4'h3, 16'h0002);
    wr(4'hB, 16'h0002);
    pulse_sync_en = 4'h1;
    pulse_int_en = 4'h1;
    pulse_start = 4'h1;
    w(1);
    pulse_start = 4'h0;
    per(0, 48);
    chk("p_int", pulse_int_q, 4'h1);
    wr(4'hB, 16'h0000);
    wr(4'h3, 16'h0000);
    per(0, 16);
    pulse_stop = 4'h1;
    w(1);
    pulse_stop = 4'h0;
    pulse_int_ack = 4'h1;
    w(1);
    pulse_int_ack = 4'h0;
    wr(4'h3, 16'h1234);
    w(40);
    rd(4'h3);
    chk("p_stop", rdv, 16'h1234);
    chk("p_ack", pulse_int_q, 4'h0);
    // Sync outputs, clock sources and cascade
    sync_plain_val = 4'h5;
    w(3);
    chk("plain", sync_out_q, 4'h5);
    wr(4'h1, 16'h0000);
    wr(4'h9, 16'h0000);
    wr(4'h2, 16'h0001);
    wr(4'hA, 16'h0001);
    timer_run = 3'h2;
    sync_toggle_mode = 4'h2;
    per(5, 2);
    t2_div_sel = 4'h2;
    per(5, 8);
    t2_src_sel = 2'h2;
    timer_run = 3'h6;
    per(5, 4);
    t2_src_sel = 2'h1;
    per(5, 8);
    wr(4'hA, 16'h0000);
    t2_src_sel = 2'h2;
    t3_src_sel = 1;
    per(5, 8);
    chk("plain2", {sync_out_q[3:2], sync_out_q[0]}, 3'h3);
    // Timer one underflow latch, request and acknowledge
    wr(4'h0, 16'h0000);
    wr(4'h8, 16'h0000);
    timer_int_en = 4'h2;
    timer_run = 3'h1;
    w(40);
    chk("t1_int", timer_int_q[1], 1'b1);
    chk("t1_irq", irq_q, 1'b1);
    timer_run = 3'h0;
    w(2);
    timer_int_ack = 4'hF;
    w(1);
    timer_int_ack = 4'h0;
    w(2);
    chk("t1_ack", timer_int_q, 4'h0);
    // Captures on falling edges, rising edges ignored
    capture_int_en = 3'h7;
    event_int_en = 1;
    for (int i = 0; i < 4; i++) begin
      pins[i] = 1;
      w(8);
      chk("no_pend", pend[i], 1'b0);
      lo = base_timer_q;
      pins[i] = 0;
      w(8);
      chk("capt", caps[16*i +: 16] >= lo && caps[16*i +: 16] <= base_timer_q,
          1'b1);
      chk("pend", pend[i], 1'b1);
      chk("irq", irq_q, 1'b1);
      {event_int_ack, capture_int_ack} = 4'h1 << i;
      w(1);
      {event_int_ack, capture_int_ack} = 4'h0;
      w(2);
      chk("ack", pend, 4'h0);
    end
    edge_condition_reg = 3'h7;
    event_pin_config = 2'h1;
    pins = 4'hF;
    w(8);
    chk("rise", pend, 4'hF);
    // Pair one acting as capture
    capture_mode = 1;
    pins = 4'h0;
    w(8);
    lo = base_timer_q;
    pins[1] = 1;
    w(8);
    rd(4'h0);
    chk("cmode", rdv >= lo && rdv <= base_timer_q, 1'b1);
    capture_mode = 0;
    // Level mode keeps setting the latch
    event_pin_config = 2'h3;
    pins[3] = 1;
    w(4);
    event_int_ack = 1;
    w(1);
    event_int_ack = 0;
    w(1);
    chk("level", event_pend_q, 1'b1);
    // Supervisor
    single_chip = 1;
    external_access_bit = 1;
    illegal_addr = 1;
    w(1);
    illegal_addr = 0;
    w(4);
    chk("ext_acc", fault_out_n_oe_n_q, 1'b1);
    service_wr = 1;
    w(1);
    service_wr = 0;
    w(10);
    chk("svc1", fault_out_n_oe_n_q, 1'b1);
    service_wr = 1;
    w(1);
    service_wr = 0;
    w(4);
    chk("soon", fault_out_n_oe_n_q, 1'b0);
    w(20);
    chk("hold", fault_out_n_oe_n_q, 1'b0);
    pulse_preset_val = 4'h5;
    pulse_preset_wr = 1;
    w(1);
    pulse_preset_wr = 0;
    do_rst;
    external_access_bit = 0;
    illegal_addr = 1;
    w(1);
    illegal_addr = 0;
    w(4);
    chk("illegal", fault_out_n_oe_n_q, 1'b0);
    chk("wake", wake_q, 1'b0);
    end_sim;
  end
endmodule // tb_tmr_top
